// file: eldp_consts.svh
// Constants for the line energy-detect power control block
// Assumes a 10 MHz system clock and a 16-bit management register port
//
// What this block does
// RULE1 - Power saving runs only while enable bit set
// RULE2 - Software should disable automatic crossover then
// RULE3 - Auto wake powers up at data threshold
// RULE4 - Auto sleep powers down without line energy
// RULE5 - Manual toggle forces state change, self-clearing
// RULE6 - Power-up sends burst of four pulses
// RULE7 - Burst-off bit sends a single pulse
// RULE8 - Bit 10 reports current line power state
// RULE9 - Bit 9 flags error threshold, clear-on-read
// RULE10 - Bit 8 flags data threshold, clear-on-read
// RULE11 - Bits 7:4 set error event threshold
// RULE12 - Bits 3:0 set data event threshold
// RULE13 - Counters clear after two quiet seconds
// RULE14 - Disabled: stay powered, flags held zero
`ifndef ELDP_CONSTS_SVH
`define ELDP_CONSTS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ELDP_ADDR_W           5
`define ELDP_DATA_W           16
`define ELDP_ENERGY_CTRL_ADDR 5'h1d

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ELDP_BIT_ENABLE       15
`define ELDP_BIT_AUTO_WAKE    14
`define ELDP_BIT_AUTO_SLEEP   13
`define ELDP_BIT_MANUAL       12
`define ELDP_BIT_BURST_OFF    11
`define ELDP_BIT_POWER_STATE  10
`define ELDP_BIT_ERR_MET      9
`define ELDP_BIT_DATA_MET     8
`define ELDP_ERR_LIMIT_HI     7
`define ELDP_ERR_LIMIT_LO     4
`define ELDP_DATA_LIMIT_HI    3
`define ELDP_DATA_LIMIT_LO    0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ELDP_RST_ENABLE       1'b0
`define ELDP_RST_AUTO_WAKE    1'b1
`define ELDP_RST_AUTO_SLEEP   1'b1
`define ELDP_RST_BURST_OFF    1'b0
`define ELDP_RST_LIMIT        4'h1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ELDP_CLK_KHZ          10000
`define ELDP_QUIET_MS         2000
`define ELDP_BURST_PULSES     4
`define ELDP_PULSE_GAP_CYC    16

`endif

// file: eldp_pkg.sv
// Types for the line energy-detect power control block
// Assumes eldp_consts.svh is compiled alongside
package eldp_pkg;

  // Line events presented by the receive circuitry
  typedef struct packed {
    logic energy;
    logic data_ev;
    logic error_ev;
  } eldp_line_ev_t;

  // Power sequence states, Gray coded around the loop
  typedef enum logic [1:0] {
    ST_POWERED  = 2'b00,
    ST_GO_DOWN  = 2'b01,
    ST_ASLEEP   = 2'b11,
    ST_GO_UP    = 2'b10
  } eldp_state_t;

endpackage

// file: eldp_event_counter.sv
// Saturating event counter with threshold compare
// Assumes single-cycle event pulses synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none

module eldp_event_counter #(
  parameter int unsigned W = 4
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Control
  input  wire logic         clear_i,
  input  wire logic         event_i,
  input  wire logic [W-1:0] limit_i,
  // Status
  output logic              met_o
);

  logic [W-1:0] count_q;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      count_q <= '0;
    end else if (event_i && (count_q != {W{1'b1}})) begin
      count_q <= count_q + 1'b1;
    end
  end

  assign met_o = (count_q >= limit_i);

endmodule

`default_nettype wire

// file: eldp_pulse_gen.sv
// Energy-detect data pulse burst generator
// Assumes start_i is a one-cycle pulse at each line power-up
`timescale 1ns/1ps
`default_nettype none
`include "eldp_consts.svh"

module eldp_pulse_gen #(
  parameter int unsigned PULSES = `ELDP_BURST_PULSES,
  parameter int unsigned GAP    = `ELDP_PULSE_GAP_CYC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control
  input  wire logic start_i,
  input  wire logic single_i,
  // Pulse out
  output logic      pulse_o
);

  localparam int unsigned NW = $clog2(PULSES + 1);
  localparam int unsigned GW = $clog2(GAP + 1);

  logic [NW-1:0] left_q;
  logic [GW-1:0] gap_q;

  // ----------------------------------------------------------------
  // Burst sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left_q  <= '0;
      gap_q   <= '0;
      pulse_o <= 1'b0;
    end else if (start_i) begin
      left_q  <= single_i ? NW'(1) : NW'(PULSES); // RULE6 RULE7
      gap_q   <= '0;
      pulse_o <= 1'b0;
    end else if (left_q != '0 && gap_q == '0) begin
      pulse_o <= 1'b1;
      left_q  <= left_q - 1'b1;
      gap_q   <= GW'(GAP);
    end else begin
      pulse_o <= 1'b0;
      if (gap_q != '0) begin
        gap_q <= gap_q - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// file: eldp_top.sv
// Energy-detect power control with its management register
// Assumes register port strobes come from the serial management logic
// and line data and error events are synchronous single-cycle pulses, energy a level
`timescale 1ns/1ps
`default_nettype none
`include "eldp_consts.svh"

module eldp_top #(
  parameter int unsigned QUIET_CYC = `ELDP_QUIET_MS * `ELDP_CLK_KHZ,
  parameter int unsigned PULSES    = `ELDP_BURST_PULSES,
  parameter int unsigned GAP       = `ELDP_PULSE_GAP_CYC
) (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Management register port
  input  wire logic [`ELDP_ADDR_W-1:0]    reg_addr_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  input  wire logic [`ELDP_DATA_W-1:0]    reg_wdata_i,
  output logic      [`ELDP_DATA_W-1:0]    reg_rdata_o,
  // Line events
  input  wire eldp_pkg::eldp_line_ev_t    line_ev_i,
  // Line circuitry control
  output logic                            line_power_up_o,
  output logic                            ed_pulse_o
);

  localparam int unsigned TW = $clog2(QUIET_CYC + 1);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic              energy_mode_enable_q;
  logic              auto_wake_q;
  logic              auto_sleep_q;
  logic              pulse_burst_off_q;
  logic [3:0]        error_event_limit_q;
  logic [3:0]        data_event_limit_q;
  logic              error_limit_reached_q;
  logic              data_limit_reached_q;
  logic              manual_power_toggle;
  logic              sel;
  logic              wr_hit;
  logic              rd_hit;
  logic              data_met;
  logic              err_met;
  logic              data_met_q;
  logic              err_met_q;
  logic              cnt_clear;
  logic [TW-1:0]     quiet_q;
  logic              quiet_done;
  logic              power_up_start;
  logic [`ELDP_DATA_W-1:0] reg_view;
  eldp_pkg::eldp_state_t   state_q;
  eldp_pkg::eldp_state_t   state_d;

  assign sel    = (reg_addr_i == `ELDP_ENERGY_CTRL_ADDR);
  assign wr_hit = reg_wr_i && sel;
  assign rd_hit = reg_rd_i && sel;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      energy_mode_enable_q <= `ELDP_RST_ENABLE;
      auto_wake_q          <= `ELDP_RST_AUTO_WAKE;
      auto_sleep_q         <= `ELDP_RST_AUTO_SLEEP;
      pulse_burst_off_q    <= `ELDP_RST_BURST_OFF;
      error_event_limit_q  <= `ELDP_RST_LIMIT;
      data_event_limit_q   <= `ELDP_RST_LIMIT;
    end else if (wr_hit) begin
      energy_mode_enable_q <= reg_wdata_i[`ELDP_BIT_ENABLE];
      auto_wake_q          <= reg_wdata_i[`ELDP_BIT_AUTO_WAKE];
      auto_sleep_q         <= reg_wdata_i[`ELDP_BIT_AUTO_SLEEP];
      pulse_burst_off_q    <= reg_wdata_i[`ELDP_BIT_BURST_OFF];
      error_event_limit_q  <= reg_wdata_i[`ELDP_ERR_LIMIT_HI:`ELDP_ERR_LIMIT_LO]; // RULE11
      data_event_limit_q   <= reg_wdata_i[`ELDP_DATA_LIMIT_HI:`ELDP_DATA_LIMIT_LO]; // RULE12
    end
  end

  // Self-clearing: acts in the write cycle only and reads back as zero
  assign manual_power_toggle = wr_hit && reg_wdata_i[`ELDP_BIT_MANUAL]; // RULE5

  // ----------------------------------------------------------------
  // Event counters
  // ----------------------------------------------------------------
  eldp_event_counter #(
    .W       (4)
  ) u_data_cnt (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i (cnt_clear),
    .event_i (line_ev_i.data_ev),
    .limit_i (data_event_limit_q),
    .met_o   (data_met)
  );

  eldp_event_counter #(
    .W       (4)
  ) u_err_cnt (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i (cnt_clear),
    .event_i (line_ev_i.error_ev),
    .limit_i (error_event_limit_q),
    .met_o   (err_met)
  );

  // ----------------------------------------------------------------
  // Quiet timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !energy_mode_enable_q || line_ev_i.data_ev || quiet_done) begin
      quiet_q <= '0;
    end else begin
      quiet_q <= quiet_q + 1'b1;
    end
  end

  assign quiet_done = (quiet_q == TW'(QUIET_CYC - 1));
  assign cnt_clear  = !energy_mode_enable_q || quiet_done || (state_q == eldp_pkg::ST_GO_UP); // RULE13 RULE14

  // ----------------------------------------------------------------
  // Power sequence
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      eldp_pkg::ST_POWERED: begin
        if (manual_power_toggle) begin
          state_d = eldp_pkg::ST_GO_DOWN; // RULE5
        end else if (auto_sleep_q && !line_ev_i.energy) begin
          state_d = eldp_pkg::ST_GO_DOWN; // RULE4
        end
      end
      eldp_pkg::ST_GO_DOWN: begin
        state_d = eldp_pkg::ST_ASLEEP;
      end
      eldp_pkg::ST_ASLEEP: begin
        if (manual_power_toggle) begin
          state_d = eldp_pkg::ST_GO_UP; // RULE5
        end else if (auto_wake_q && data_met) begin
          state_d = eldp_pkg::ST_GO_UP; // RULE3
        end
      end
      eldp_pkg::ST_GO_UP: begin
        state_d = eldp_pkg::ST_POWERED;
      end
      default: begin
        state_d = eldp_pkg::ST_POWERED;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !energy_mode_enable_q) begin
      state_q <= eldp_pkg::ST_POWERED; // RULE1 RULE14
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_power_up_o <= 1'b1;
    end else begin
      line_power_up_o <= !energy_mode_enable_q || (state_d == eldp_pkg::ST_POWERED)
                         || (state_d == eldp_pkg::ST_GO_DOWN); // RULE14
    end
  end

  assign power_up_start = energy_mode_enable_q && (state_q == eldp_pkg::ST_GO_UP);

  // ----------------------------------------------------------------
  // Pulse burst at power-up
  // ----------------------------------------------------------------
  eldp_pulse_gen #(
    .PULSES   (PULSES),
    .GAP      (GAP)
  ) u_pulse (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .start_i  (power_up_start), // RULE6
    .single_i (pulse_burst_off_q), // RULE7
    .pulse_o  (ed_pulse_o)
  );

  // ----------------------------------------------------------------
  // Threshold flags, set wins over clear-on-read
  // ----------------------------------------------------------------
  // Previous compare, so the event that reaches a limit sets its flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_met_q <= 1'b0;
      err_met_q  <= 1'b0;
    end else begin
      data_met_q <= data_met;
      err_met_q  <= err_met;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !energy_mode_enable_q) begin
      data_limit_reached_q <= 1'b0; // RULE14
    end else if (data_met && (!data_met_q || line_ev_i.data_ev)) begin
      data_limit_reached_q <= 1'b1; // RULE10
    end else if (rd_hit) begin
      data_limit_reached_q <= 1'b0; // RULE10
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !energy_mode_enable_q) begin
      error_limit_reached_q <= 1'b0; // RULE14
    end else if (err_met && (!err_met_q || line_ev_i.error_ev)) begin
      error_limit_reached_q <= 1'b1; // RULE9
    end else if (rd_hit) begin
      error_limit_reached_q <= 1'b0; // RULE9
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    reg_view = '0;
    reg_view[`ELDP_BIT_ENABLE]      = energy_mode_enable_q;
    reg_view[`ELDP_BIT_AUTO_WAKE]   = auto_wake_q;
    reg_view[`ELDP_BIT_AUTO_SLEEP]  = auto_sleep_q;
    reg_view[`ELDP_BIT_BURST_OFF]   = pulse_burst_off_q;
    reg_view[`ELDP_BIT_POWER_STATE] = line_power_up_o; // RULE8
    reg_view[`ELDP_BIT_ERR_MET]     = error_limit_reached_q; // RULE9
    reg_view[`ELDP_BIT_DATA_MET]    = data_limit_reached_q; // RULE10
    reg_view[`ELDP_ERR_LIMIT_HI:`ELDP_ERR_LIMIT_LO]   = error_event_limit_q;
    reg_view[`ELDP_DATA_LIMIT_HI:`ELDP_DATA_LIMIT_LO] = data_event_limit_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= sel ? reg_view : '0;
    end
  end

endmodule

`default_nettype wire

// file: eldp_link_partner.sv
// Link partner model: drives line events and counts received pulses
// Assumes the bench calls its tasks; drives at the falling clock edge
`timescale 1ns/1ps
`default_nettype none

module eldp_link_partner (
  // Clock
  input  wire logic             clk_i,
  // Line side
  input  wire logic             ed_pulse_i,
  output eldp_pkg::eldp_line_ev_t line_ev_o,
  output logic [7:0]            pulse_cnt_o
);
  initial line_ev_o = '0;
  initial pulse_cnt_o = 8'h00;
  // ----------------------------------------------------------------
  // Received pulse counter
  // ----------------------------------------------------------------
  always @(posedge clk_i) if (ed_pulse_i) pulse_cnt_o <= pulse_cnt_o + 8'h01;
  task automatic clr();
    @(negedge clk_i) pulse_cnt_o = 8'h00;
  endtask
  task automatic set_energy(input logic e);
    @(negedge clk_i) line_ev_o.energy = e;
  endtask
  // ----------------------------------------------------------------
  // One-cycle event pulses with a one-cycle gap
  // ----------------------------------------------------------------
  task automatic send(input logic err, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i) {line_ev_o.data_ev, line_ev_o.error_ev} = {!err, err};
      @(negedge clk_i) {line_ev_o.data_ev, line_ev_o.error_ev} = 2'b00;
    end
  endtask
endmodule
`default_nettype wire

// file: eldp_top_chk.sv
// Checker for the energy-detect power control block
// Assumes binding to eldp_top; register writes mirrored in a shadow
`timescale 1ns/1ps
`default_nettype none
`include "eldp_consts.svh"

module eldp_top_chk #(
  parameter int unsigned GAP = `ELDP_PULSE_GAP_CYC
) (
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic [`ELDP_ADDR_W-1:0] reg_addr_i,
  input wire logic                    reg_wr_i,
  input wire logic                    reg_rd_i,
  input wire logic [`ELDP_DATA_W-1:0] reg_wdata_i,
  input wire logic [`ELDP_DATA_W-1:0] reg_rdata_o,
  input wire eldp_pkg::eldp_line_ev_t line_ev_i,
  input wire logic                    line_power_up_o,
  input wire logic                    ed_pulse_o
);
  localparam int STEP = GAP + 1;
  logic [15:0] sh_q;
  logic        rd_m;
  logic        ev;
  assign rd_m = reg_rd_i && reg_addr_i == 5'h1d;
  assign ev = line_ev_i.data_ev || line_ev_i.error_ev;
  always_ff @(posedge clk_i) begin
    if (rst_i) sh_q <= 16'h6011;
    else if (reg_wr_i && reg_addr_i == 5'h1d) sh_q <= reg_wdata_i;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_hold; !$past(reg_rd_i) |-> $stable(reg_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unmap; reg_rd_i && reg_addr_i != 5'h1d |=> reg_rdata_o == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_man0; rd_m |=> !reg_rdata_o[12]; endproperty
  a_man0: assert property (p_man0) else $error("manual bit read back");
  property p_fields;
    rd_m |=> {reg_rdata_o[15:13], reg_rdata_o[11], reg_rdata_o[7:0]}
             == {sh_q[15:13], sh_q[11], sh_q[7:0]};
  endproperty
  a_fields: assert property (p_fields) else $error("field readback");
  property p_dis; !sh_q[15] [*4] |-> line_power_up_o; endproperty
  a_dis: assert property (p_dis) else $error("disabled but powered down");
  property p_nodown; $fell(line_power_up_o) |-> $past(sh_q[15]); endproperty
  a_nodown: assert property (p_nodown) else $error("power down while disabled");
  property p_burst;
    $rose(line_power_up_o) && sh_q[15] && !sh_q[11] |-> ##1 ed_pulse_o
      ##STEP ed_pulse_o ##STEP ed_pulse_o ##STEP ed_pulse_o;
  endproperty
  a_burst: assert property (p_burst) else $error("burst of four missing");
  property p_single;
    $rose(line_power_up_o) && sh_q[15] && sh_q[11] |-> ##1 ed_pulse_o ##1 !ed_pulse_o [*8];
  endproperty
  a_single: assert property (p_single) else $error("single pulse wrong");
  property p_sleep;
    sh_q[15] && sh_q[13] && line_power_up_o && !line_ev_i.energy |-> ##[1:6] !line_power_up_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no auto power down");
  property p_cor;
    (!ev && !reg_wr_i) ##1 (rd_m && !ev && !reg_wr_i) ##1 (!ev && !reg_wr_i) ##1 rd_m
      |=> reg_rdata_o[9:8] == 2'b00;
  endproperty
  a_cor: assert property (p_cor) else $error("flag not cleared on read");
endmodule

bind eldp_top eldp_top_chk #(.GAP(GAP)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .line_ev_i(line_ev_i),
  .line_power_up_o(line_power_up_o), .ed_pulse_o(ed_pulse_o));
`default_nettype wire

// file: tb_line_energy_detect_power.sv
// Testbench for the energy-detect power control block
// Assumes 10 MHz clock, shortened quiet time and pulse gap
`timescale 1ns/1ps
`default_nettype none

module tb_line_energy_detect_power;
  logic                    clk_i = 1'b0;
  logic                    rst_i = 1'b1;
  logic [4:0]              reg_addr_i = 5'h00;
  logic                    reg_wr_i = 1'b0;
  logic                    reg_rd_i = 1'b0;
  logic [15:0]             reg_wdata_i = 16'h0000;
  logic [15:0]             reg_rdata_o;
  eldp_pkg::eldp_line_ev_t line_ev_i;
  logic                    line_power_up_o;
  logic                    ed_pulse_o;
  logic [7:0]              pcnt;
  logic [15:0]             d;
  int                      error_cnt = 0;
  int                      checks = 0;
  int                      cyc = 0;
  always #50 clk_i = ~clk_i;
  eldp_top #(.QUIET_CYC(50), .GAP(4)) u_eldp_top (.clk_i(clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .line_ev_i(line_ev_i),
    .line_power_up_o(line_power_up_o), .ed_pulse_o(ed_pulse_o));
  eldp_link_partner u_eldp_link_partner (.clk_i(clk_i), .ed_pulse_i(ed_pulse_o),
    .line_ev_o(line_ev_i), .pulse_cnt_o(pcnt));
  // ----------------------------------------------------------------
  // Register access and compare tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(negedge clk_i) {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, v, 1'b1};
    @(negedge clk_i) reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(negedge clk_i) {reg_addr_i, reg_rd_i} = {a, 1'b1};
    @(negedge clk_i) reg_rd_i = 1'b0;
    d = reg_rdata_o;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(negedge clk_i);
    rst_i = 1'b0;
    rd(5'h1d);
    chk(d & 16'hfbff, 16'h6011, "reset value");
    wr(5'h03, 16'hffff);
    rd(5'h03);
    chk(d, 16'h0000, "unmapped read");
    rd(5'h1d);
    chk(d & 16'hfbff, 16'h6011, "unmapped write leaked");
    u_eldp_link_partner.send(1'b0, 4);
    u_eldp_link_partner.send(1'b1, 4);
    rd(5'h1d);
    chk({14'h0, line_power_up_o, d[9] | d[8]}, 16'h0002, "disabled");
    $display("test reset_disabled done");
    wr(5'h1d, 16'he012);
    idle(8);
    rd(5'h1d);
    chk({15'h0, line_power_up_o | d[10]}, 16'h0000, "auto sleep");
    u_eldp_link_partner.set_energy(1'b1);
    u_eldp_link_partner.send(1'b0, 1);
    idle(80);
    u_eldp_link_partner.send(1'b0, 1);
    idle(4);
    chk({15'h0, line_power_up_o}, 16'h0000, "quiet clear");
    u_eldp_link_partner.clr();
    u_eldp_link_partner.send(1'b0, 1);
    idle(40);
    chk({15'h0, line_power_up_o}, 16'h0001, "auto wake");
    chk({8'h0, pcnt}, 16'h0004, "burst");
    $display("test sleep_wake done");
    u_eldp_link_partner.send(1'b0, 3);
    rd(5'h1d);
    chk(d & 16'h0700, 16'h0500, "data met");
    rd(5'h1d);
    chk(d & 16'h0300, 16'h0000, "data cleared");
    u_eldp_link_partner.send(1'b1, 1);
    idle(4);
    rd(5'h1d);
    chk({d[9], 14'h0, line_power_up_o}, 16'h8001, "error met");
    $display("test flags done");
    wr(5'h1d, 16'h8812);
    wr(5'h1d, 16'h9812);
    idle(8);
    rd(5'h1d);
    chk({d[12], 14'h0, line_power_up_o}, 16'h0000, "manual down");
    u_eldp_link_partner.clr();
    wr(5'h1d, 16'h9812);
    idle(40);
    chk({7'h0, line_power_up_o, pcnt}, 16'h0101, "manual up single");
    $display("test manual_single done");
    test_done();
  end
endmodule
`default_nettype wire
